// ### verilog/wash_step_sequencer.sv
// Wash formula step sequencer with chemical injection timing
`timescale 1ns/1ps
// Behaviour
// R1 - Type code selects end, soak, flush, wash, rinse, finish or extract behaviour
// R2 - Step timer clears and starts at bath level, or extract speed command
// R3 - Step ends when elapsed time equals programmed step time
// R4 - Step time is two minute digits plus quarter digit, at most 633
// R5 - No injection for extract or end-of-formula steps
// R6 - Each injection lasts 30 s, chemical 1 its configured duration
// R7 - Five chemical outputs and one manifold flush output
// R8 - Five per-step select bits, 1 injects, 0 does not
// R9 - All selected chemicals start together when bath level is reached
// R10 - Flush starts 20 s after injection ends, lasts 30 s
// R11 - Operator reconfigures at installation and after memory errors
// R12 - Chemical 1 duration per formula, up to 255 s, 0 disables
// R13 - After bath time: clockwise wash speed 4 s, then drain speed, drain
// R14 - One-second tick advances step timer and all duration counters
module wash_step_sequencer
  import wash_step_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Step program
  input  wire logic                  stepStart,
  input  wire logic [3:0]            stepTypeCode,
  input  wire logic [3:0]            minTens,
  input  wire logic [3:0]            minOnes,
  input  wire logic [1:0]            stepTimeQuarter,
  input  wire logic [NUM_CHEM-1:0]   chemSelect,
  input  wire logic [7:0]            chem1Seconds,
  // Machine status
  input  wire logic                  levelReached,
  input  wire logic                  drainSpeedReached,
  // Outputs
  output logic [1:0]                 fillTemp,
  output logic [1:0]                 motion,
  output logic [1:0]                 speed,
  output logic                       drainOpen,
  output logic                       stepDone,
  output logic                       formulaEnd,
  output logic                       settingError,
  output logic [NUM_CHEM-1:0]        chemOut,
  output logic                       manifoldFlush,
  output logic [STEP_SEC_W-1:0]      elapsed
);
  ////////////////////////////////////////////////////////////////////
  logic [31:0] divCount;
  logic [31:0] next_divCount;
  logic        tick;
  logic        next_tick;
  always_comb
  begin
    next_tick = 1'b0;
    next_divCount = divCount + 32'h1;
    if (divCount == 32'(TICK_DIV - 1))
    begin
      next_divCount = 32'h0;
      next_tick = 1'b1; // R14
    end
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      divCount <= 32'h0;
      tick <= 1'b0;
    end
    else
    begin
      divCount <= next_divCount;
      tick <= next_tick;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Step time in seconds; digits widened first so products of in-range settings cannot wrap
  logic [STEP_SEC_W-1:0] target;
  logic                  timeValid;
  assign target = (STEP_SEC_W'(minTens) * MINUTES_PER_TEN + STEP_SEC_W'(minOnes))
                  * SECONDS_PER_MINUTE
                + STEP_SEC_W'(stepTimeQuarter) * STEP_SEC_W'(SECONDS_PER_QUARTER); // R4
  assign timeValid = (minTens < MAX_MINUTES ||
                      (minTens == MAX_MINUTES && minOnes <= MAX_MINUTES_LO))
                     && minOnes <= BCD_DIGIT_MAX; // R4
  logic isExtract;
  logic isBath;
  assign isExtract = (stepTypeCode == CODE_EXTRACT);
  assign isBath = (stepTypeCode >= CODE_SOAK_LO) && (stepTypeCode <= CODE_FINISH);
  ////////////////////////////////////////////////////////////////////
  step_state_e           state;
  step_state_e           next_state;
  logic [STEP_SEC_W-1:0] timer;
  logic [STEP_SEC_W-1:0] next_timer;
  logic [STEP_SEC_W-1:0] goal;
  logic [STEP_SEC_W-1:0] next_goal;
  logic [3:0]            code;
  logic [3:0]            next_code;
  logic [NUM_CHEM-1:0]   sel;
  logic [NUM_CHEM-1:0]   next_sel;
  logic [7:0]            spin;
  logic [7:0]            next_spin;
  logic                  next_stepDone;
  logic                  next_formulaEnd;
  logic                  next_settingError;
  logic                  next_drainOpen;
  logic [1:0]            next_fillTemp;
  logic [1:0]            next_motion;
  logic [1:0]            next_speed;
  logic                  fire;
  always_comb
  begin
    next_state = state;
    next_timer = timer;
    next_goal = goal;
    next_code = code;
    next_sel = sel;
    next_spin = spin;
    next_stepDone = 1'b0;
    next_formulaEnd = formulaEnd;
    next_settingError = settingError;
    next_drainOpen = 1'b0;
    next_fillTemp = TEMP_NONE;
    next_motion = MOT_NONE;
    next_speed = SPD_NONE;
    fire = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        if (stepStart)
        begin
          next_code = stepTypeCode;
          next_goal = target;
          next_settingError = !timeValid;
          next_formulaEnd = (stepTypeCode == CODE_END); // R1
          next_sel = (isBath) ? chemSelect : '0; // R5 R8
          if (isBath || isExtract)
            next_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        next_timer = '0; // R2
        if (code == CODE_EXTRACT)
        begin
          next_motion = MOT_CW; // R1
          next_speed = SPD_EXTRACT;
          next_state = ST_RUN; // R2
        end
        else
        begin
          next_fillTemp = (code == CODE_FINISH) ? TEMP_COLD
                        : 2'(((code - CODE_SOAK_LO) % 4'h3) + 4'h1); // R1
          if (levelReached)
          begin
            fire = 1'b1; // R9
            next_state = ST_RUN; // R2
          end
        end
      end
      ST_RUN:
      begin
        if (code == CODE_EXTRACT)
        begin
          next_motion = MOT_CW;
          next_speed = SPD_EXTRACT;
        end
        else if (code >= CODE_FLUSH_LO)
        begin
          next_motion = MOT_REVERSE; // R1
          next_speed = SPD_WASH;
        end
        if (timer == goal)
        begin
          next_spin = '0;
          if (code == CODE_EXTRACT)
          begin
            next_stepDone = 1'b1; // R3
            next_state = ST_IDLE;
          end
          else
            next_state = ST_SPIN; // R3
        end
        else if (tick)
          next_timer = timer + 1'b1; // R14
      end
      ST_SPIN:
      begin
        next_motion = MOT_CW; // R13
        next_speed = SPD_WASH;
        if (tick)
          next_spin = spin + 8'h01;
        if (spin == SPIN_SECONDS)
          next_state = ST_DRAIN;
      end
      ST_DRAIN:
      begin
        next_motion = MOT_CW;
        next_speed = SPD_DRAIN; // R13
        if (drainSpeedReached)
        begin
          next_drainOpen = 1'b1; // R13
          next_stepDone = 1'b1;
          next_state = ST_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= ST_IDLE;
      timer <= '0;
      goal <= '0;
      code <= CODE_END;
      sel <= '0;
      spin <= 8'h00;
      stepDone <= 1'b0;
      formulaEnd <= 1'b0;
      settingError <= 1'b0;
      drainOpen <= 1'b0;
      fillTemp <= TEMP_NONE;
      motion <= MOT_NONE;
      speed <= SPD_NONE;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
      goal <= next_goal;
      code <= next_code;
      sel <= next_sel;
      spin <= next_spin;
      stepDone <= next_stepDone;
      formulaEnd <= next_formulaEnd;
      settingError <= next_settingError;
      drainOpen <= next_drainOpen;
      fillTemp <= next_fillTemp;
      motion <= next_motion;
      speed <= next_speed;
    end
  end
  assign elapsed = timer;
  ////////////////////////////////////////////////////////////////////
  // Chemical channels; counters hold the live level, outputs re-registered
  logic [NUM_CHEM-1:0] chemLive;
  genvar g;
  generate
    for (g = 0; g < NUM_CHEM; g++)
    begin : g_chem
      inject_timer u_chem (
        .clk     (clk),
        .srst    (srst),
        .tick    (tick),
        .start   (fire && sel[g]), // R9
        .seconds ((g == 0) ? chem1Seconds : CHEM_SECONDS), // R6 R12
        .active  (chemLive[g])
      ); // R7
    end
  endgenerate
  // Flush: delay after the last injection falls, then fixed on time
  logic       anyChem;
  logic       anyChemD;
  logic [7:0] gap;
  logic [7:0] next_gap;
  logic       flushLive;
  assign anyChem = |chemLive;
  always_comb
  begin
    next_gap = gap;
    if (anyChem)
      next_gap = 8'h00;
    else if (anyChemD)
      next_gap = FLUSH_DELAY_SECONDS; // R10
    else if (tick && gap != 8'h00)
      next_gap = gap - 8'h01;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      gap <= 8'h00;
      anyChemD <= 1'b0;
      chemOut <= '0;
      manifoldFlush <= 1'b0;
    end
    else
    begin
      gap <= next_gap;
      anyChemD <= anyChem;
      chemOut <= chemLive;
      manifoldFlush <= flushLive;
    end
  end
  inject_timer u_flush (
    .clk     (clk),
    .srst    (srst),
    .tick    (tick),
    .start   (gap == 8'h01 && tick && !anyChem), // R10
    .seconds (FLUSH_ON_SECONDS),
    .active  (flushLive)
  );
  ////////////////////////////////////////////////////////////////////
  property p_extract_no_chem;
    @(posedge clk) disable iff (srst)
      (state == ST_WAIT && code == CODE_EXTRACT) |-> sel == '0 && !fire;
  endproperty
  a_extract_no_chem: assert property (p_extract_no_chem) else $error("chem in extract"); // R5
  property p_done_on_match;
    @(posedge clk) disable iff (srst)
      (state == ST_RUN && timer == goal && code == CODE_EXTRACT) |=> stepDone;
  endproperty
  a_done_on_match: assert property (p_done_on_match) else $error("step not ended"); // R3
  property p_timer_zero;
    @(posedge clk) disable iff (srst)
      (state == ST_WAIT) |=> timer == '0;
  endproperty
  a_timer_zero: assert property (p_timer_zero) else $error("timer not cleared"); // R2
  property p_chem_start;
    @(posedge clk) disable iff (srst)
      (fire && sel[1]) |=> ##1 chemOut[1];
  endproperty
  a_chem_start: assert property (p_chem_start) else $error("chem not started"); // R9
  property p_spin_cw;
    @(posedge clk) disable iff (srst)
      (state == ST_SPIN) |=> motion == MOT_CW && speed == SPD_WASH;
  endproperty
  a_spin_cw: assert property (p_spin_cw) else $error("spin motion wrong"); // R13
  property p_extract_motion;
    @(posedge clk) disable iff (srst)
      (state == ST_RUN && code == CODE_EXTRACT) |=> speed == SPD_EXTRACT;
  endproperty
  a_extract_motion: assert property (p_extract_motion) else $error("extract speed"); // R1
  property p_no_flush_during_chem;
    @(posedge clk) disable iff (srst)
      anyChem |=> ##1 !$rose(manifoldFlush);
  endproperty
  a_no_flush_during_chem: assert property (p_no_flush_during_chem) else $error("flush early"); // R10
  property p_tick_single;
    @(posedge clk) disable iff (srst)
      tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick too long"); // R14
  c_bath: cover property (@(posedge clk) disable iff (srst) state == ST_DRAIN ##1 stepDone);
  c_extract: cover property (@(posedge clk) disable iff (srst) stepDone && code == CODE_EXTRACT);
  c_flush: cover property (@(posedge clk) disable iff (srst) $rose(manifoldFlush));
endmodule

// ### verilog/wash_step_pkg.sv
// Constants and types shared by the wash step sequencer
package wash_step_pkg;
  localparam int CLK_HZ = 200000000;
  localparam int TICK_CYCLES = CLK_HZ;
  localparam logic [3:0] CODE_END = 4'h0;
  localparam logic [3:0] CODE_SOAK_LO = 4'h1;
  localparam logic [3:0] CODE_FLUSH_LO = 4'h4;
  localparam logic [3:0] CODE_FINISH = 4'hd;
  localparam logic [3:0] CODE_EXTRACT = 4'he;
  localparam int NUM_CHEM = 5;
  localparam logic [7:0] CHEM_SECONDS = 8'h1e;
  localparam logic [7:0] CHEM1_DEFAULT = 8'h1e;
  localparam logic [7:0] FLUSH_DELAY_SECONDS = 8'h14;
  localparam logic [7:0] FLUSH_ON_SECONDS = 8'h1e;
  localparam logic [7:0] SPIN_SECONDS = 8'h04;
  localparam logic [3:0] MAX_MINUTES = 4'h6;
  localparam logic [3:0] MAX_MINUTES_LO = 4'h3;
  localparam logic [1:0] MAX_QUARTER = 2'h3;
  localparam logic [3:0] SECONDS_PER_QUARTER = 4'hf;
  localparam int STEP_SEC_W = 12;
  localparam logic [STEP_SEC_W-1:0] MINUTES_PER_TEN = 12'h00a;
  localparam logic [STEP_SEC_W-1:0] SECONDS_PER_MINUTE = 12'h03c;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [1:0] TEMP_NONE = 2'h0;
  localparam logic [1:0] TEMP_HOT = 2'h1;
  localparam logic [1:0] TEMP_COLD = 2'h2;
  localparam logic [1:0] TEMP_SPLIT = 2'h3;
  localparam logic [1:0] MOT_NONE = 2'h0;
  localparam logic [1:0] MOT_REVERSE = 2'h1;
  localparam logic [1:0] MOT_CW = 2'h2;
  localparam logic [1:0] SPD_NONE = 2'h0;
  localparam logic [1:0] SPD_WASH = 2'h1;
  localparam logic [1:0] SPD_DRAIN = 2'h2;
  localparam logic [1:0] SPD_EXTRACT = 2'h3;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_WAIT  = 5'b00010,
    ST_RUN   = 5'b00100,
    ST_SPIN  = 5'b01000,
    ST_DRAIN = 5'b10000
  } step_state_e;
endpackage

// ### verilog/inject_timer.sv
// One timed chemical or manifold-flush output channel
`timescale 1ns/1ps
module inject_timer
  import wash_step_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Control
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic [7:0] seconds,
  // Output
  output logic            active
);
  logic [7:0] remain;
  logic [7:0] next_remain;
  always_comb
  begin
    next_remain = remain;
    if (start)
      next_remain = seconds; // R6
    else if (tick && remain != 8'h00)
      next_remain = remain - 8'h01; // R14
  end
  always_ff @(posedge clk)
  begin
    if (srst)
      remain <= 8'h00;
    else
      remain <= next_remain;
  end
  assign active = (remain != 8'h00);
endmodule

// ### testbench/drive_model.sv
// Behavioural fill level and drum speed feedback for the sequencer
`timescale 1ns/1ps
module drive_model
  import wash_step_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Machine commands
  input  wire logic [1:0] fillTemp,
  input  wire logic [1:0] speed,
  input  wire logic       drainOpen,
  input  wire logic [7:0] lagCycles,
  // Feedback
  output logic            levelReached,
  output logic            drainSpeedReached
);
  logic [7:0] fillCnt;
  logic [7:0] spinCnt;
  ////////////////////////////////////////////////////////////////////////////////
  // Level stays up until the drain opens, as a real bath would
  always_ff @(posedge clk)
  begin
    if (srst || drainOpen)
    begin
      fillCnt <= 8'h00;
      levelReached <= 1'b0;
    end
    else if (fillTemp != TEMP_NONE && !levelReached)
    begin
      fillCnt <= fillCnt + 8'h01;
      levelReached <= (fillCnt >= lagCycles);
    end
    spinCnt <= (srst || speed != SPD_DRAIN) ? 8'h00 : spinCnt + {7'h00, spinCnt < lagCycles};
    drainSpeedReached <= !srst && speed == SPD_DRAIN && spinCnt >= lagCycles;
  end
endmodule

// ### testbench/wash_step_sequencer_tb.sv
// Self-checking bench for the wash step sequencer
`timescale 1ns/1ps
module wash_step_sequencer_tb
  import wash_step_pkg::*;
;
  localparam int TD = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic stepStart = 1'b0;
  logic [3:0] code = 4'h0, mt = 4'h0, mo = 4'h0;
  logic [1:0] mq = 2'h0;
  logic [4:0] sel = 5'h00;
  logic [7:0] c1s = CHEM1_DEFAULT, lag = 8'h08;
  logic lvl, dsr, drainOpen, stepDone, formulaEnd, settingError, manifoldFlush;
  logic [1:0] fillTemp, motion, speed;
  logic [4:0] chemOut;
  logic [11:0] elapsed;
  int fails = 0, compares = 0, cyc = 0, n;
  // Row layout: type code, fill temperature, motion, speed
  logic [9:0] row [14] = '{10'h050, 10'h0a0, 10'h0f0, 10'h115, 10'h165, 10'h1b5, 10'h1d5,
    10'h225, 10'h275, 10'h295, 10'h2e5, 10'h335, 10'h365, 10'h38b};
  // Time digits, quarter, expected setting error
  logic [10:0] bad [3] = '{11'h31e, 11'h321, 11'h051};
  ////////////////////////////////////////////////////////////////////////////////
  always #2.5 clk = ~clk;
  wash_step_sequencer #(.TICK_DIV(TD)) u_dut (.clk(clk), .srst(srst), .stepStart(stepStart),
    .stepTypeCode(code), .minTens(mt), .minOnes(mo), .stepTimeQuarter(mq), .chemSelect(sel),
    .chem1Seconds(c1s), .levelReached(lvl), .drainSpeedReached(dsr), .fillTemp(fillTemp),
    .motion(motion), .speed(speed), .drainOpen(drainOpen), .stepDone(stepDone),
    .formulaEnd(formulaEnd), .settingError(settingError), .chemOut(chemOut),
    .manifoldFlush(manifoldFlush), .elapsed(elapsed));
  drive_model u_drv (.clk(clk), .srst(srst), .fillTemp(fillTemp), .speed(speed),
    .drainOpen(drainOpen), .lagCycles(lag), .levelReached(lvl), .drainSpeedReached(dsr));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Durations carry one tick of slack since the tick phase is free-running
  task automatic chkr(input int got, input int sec);
    compares++;
    if (got < TD * sec - TD - 5 || got > TD * sec + TD + 5)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, TD * sec);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(negedge clk);
  endtask
  function automatic logic pr(input int k);
    case (k)
      0: pr = lvl;
      1: pr = motion == MOT_CW;
      2: pr = speed == SPD_WASH;
      3: pr = stepDone;
      4: pr = chemOut[0];
      5: pr = |chemOut;
      default: pr = manifoldFlush;
    endcase
  endfunction
  // Cycles until probe k leaves level v, bounded so a stuck output cannot hang
  task automatic span(input int k, input logic v, output int c);
    c = 0;
    while (pr(k) === v && c < 20000)
    begin
      tk(1);
      c++;
    end
  endtask
  task automatic go(input logic [3:0] c, t, o, input logic [1:0] q, input logic [4:0] s);
    @(posedge clk);
    stepStart <= 1'b1;
    code <= c;
    mt <= t;
    mo <= o;
    mq <= q;
    sel <= s;
    @(posedge clk);
    stepStart <= 1'b0;
    tk(3);
  endtask
  task automatic rst(input int k);
    @(posedge clk);
    srst <= 1'b1;
    repeat (k) @(posedge clk);
    srst <= 1'b0;
    tk(1);
    chk({fillTemp, motion, speed, drainOpen, stepDone, formulaEnd, settingError, chemOut,
      manifoldFlush}, 16'h0000);
    chk({4'h0, elapsed}, 16'h0000);
  endtask
  task automatic close_out;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst(10);
    $display("Test reset done");
    go(CODE_END, 4'h0, 4'h0, 2'h1, 5'h1f);
    chk({formulaEnd, chemOut, motion, speed}, 16'h0200);
    $display("Test end code done");
    for (int i = 0; i < 14; i++)
    begin
      lag <= i[0] ? 8'h28 : 8'h08;
      go(row[i][9:6], 4'h0, 4'h0, 2'h1, row[i][9:6] == CODE_EXTRACT ? 5'h1f : 5'h00);
      chk({formulaEnd, fillTemp}, {1'b0, row[i][5:4]});
      if (row[i][9:6] != CODE_EXTRACT)
      begin
        span(0, 1'b0, n);
        tk(3);
      end
      chk({motion, speed, chemOut}, {row[i][3:0], 5'h00});
      if (row[i][9:6] == CODE_EXTRACT)
      begin
        span(3, 1'b0, n);
        chkr(n, 15);
      end
      else
      begin
        span(1, 1'b0, n);
        chkr(n, 15);
        span(2, 1'b1, n);
        chkr(n, 4);
        chk(speed, SPD_DRAIN);
        span(3, 1'b0, n);
        chk(drainOpen, 1'b1);
      end
      tk(2);
      $display("Test row %0d done", i);
    end
    c1s <= 8'h05;
    go(4'h7, 4'h0, 4'h0, 2'h1, 5'h1f);
    span(0, 1'b0, n);
    span(5, 1'b0, n);
    chk(n < 5, 1'b1);
    chk(chemOut, 5'h1f);
    span(4, 1'b1, n);
    chkr(n, 5);
    chk(chemOut, 5'h1e);
    span(5, 1'b1, n);
    chkr(n, 25);
    chk(manifoldFlush, 1'b0);
    span(6, 1'b0, n);
    chkr(n, 20);
    span(6, 1'b1, n);
    chkr(n, 30);
    $display("Test injection done");
    c1s <= 8'h00;
    go(4'h8, 4'h0, 4'h0, 2'h1, 5'h01);
    span(0, 1'b0, n);
    tk(4);
    chk(chemOut, 5'h00);
    span(3, 1'b0, n);
    chk(manifoldFlush, 1'b0);
    $display("Test zero duration done");
    go(CODE_EXTRACT, 4'h0, 4'h8, 2'h1, 5'h00);
    span(3, 1'b0, n);
    chkr(n, 495);
    chk({4'h0, elapsed}, 16'h01ef);
    $display("Test long step done");
    for (int k = 0; k < 3; k++)
    begin
      go(CODE_EXTRACT, bad[k][10:7], bad[k][6:3], bad[k][2:1], 5'h00);
      chk(settingError, bad[k][0]);
      rst(2);
      c1s <= CHEM1_DEFAULT;
      $display("Test setting %0d done", k);
    end
    close_out;
  end
endmodule
